// File: pcg_pkg.sv
// constants, register map and types for the peripheral clock gating block
// assumes a 32-bit word register port with 12-bit byte addresses
package pcg_pkg;

   // register byte offsets
   localparam logic [11:0] OFF_RUN_CLOCK_CONFIG   = 12'h060;
   localparam logic [11:0] OFF_RUN_PERIPH_GATE    = 12'h104;
   localparam logic [11:0] OFF_RUN_PORT_GATE      = 12'h108;
   localparam logic [11:0] OFF_SLEEP_PERIPH_GATE  = 12'h114;
   localparam logic [11:0] OFF_SLEEP_PORT_GATE    = 12'h118;
   localparam logic [11:0] OFF_DEEP_PERIPH_GATE   = 12'h124;
   localparam logic [11:0] OFF_DEEP_PORT_GATE     = 12'h128;
   localparam logic [11:0] OFF_IRQ_STATUS         = 12'h130;
   localparam logic [11:0] OFF_IRQ_ENABLE         = 12'h134;
   localparam logic [11:0] OFF_IRQ_CLEAR          = 12'h138;

   // writable bits of each gating register
   localparam logic [31:0] PORT_MASK   = 32'h0000_001F;
   localparam logic [31:0] PERIPH_MASK = 32'h0107_1013;
   localparam int          PORT_W      = 5;

   // field positions
   localparam int BIT_AUTO_GATE       = 27;
   localparam int BIT_PORT_A          = 0;
   localparam int BIT_COMPARATOR0     = 24;
   localparam int BIT_GP_COUNTER0     = 16;
   localparam int BIT_TWOWIRE0        = 12;
   localparam int BIT_SYNC_SERIAL0    = 4;
   localparam int BIT_ASYNC_SERIAL0   = 0;
   localparam int IRQ_FAULT           = 0;
   localparam int IRQ_PWR_CHANGE      = 1;
   localparam int IRQ_W               = 2;

   // reset values
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SLEEP,
      PWR_DEEP
   } pcg_pwr_t;

   typedef struct packed {
      logic [31:0]      runPort;
      logic [31:0]      sleepPort;
      logic [31:0]      deepPort;
      logic [31:0]      runPeriph;
      logic [31:0]      sleepPeriph;
      logic [31:0]      deepPeriph;
      logic             autoGate;
      pcg_pwr_t         pwr;
      logic [31:0]      portEn;
      logic [31:0]      periphEn;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqEn;
      logic [31:0]      rdData;
   } pcg_state_t;

endpackage : pcg_pkg

// File: pcg_clock_gate.sv
// peripheral clock gating control: gating registers, power state select,
// clock enables for the gating cells and bus fault answer for gated units
// assumes sleep requests and unit accesses come from logic on clk
`timescale 1ns/1ps

module pcg_clock_gate
   import pcg_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // register port
   input  wire logic [11:0]       regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [31:0]       regRdData,
   // power state requests
   input  wire logic              sleepReq,
   input  wire logic              deepSleepReq,
   // clock enables to the gating cells
   output logic      [PORT_W-1:0] portClkEn,
   output logic      [31:0]       periphClkEn,
   // unit access check
   input  wire logic              accValid,
   input  wire logic              accPort,
   input  wire logic [4:0]        accBit,
   output logic                   accFault,
   // interrupt
   output logic                   irq
);

   pcg_state_t sQ;
   pcg_state_t sD;

   // pick the enable set that applies in a power state
   function automatic logic [31:0] pcgSelect(
      input pcg_pwr_t    pwr,
      input logic        autoGate,
      input logic [31:0] runSet,
      input logic [31:0] sleepSet,
      input logic [31:0] deepSet,
      input logic [31:0] mask
   );
      logic [31:0] sel;
      sel = runSet;
      if (autoGate) begin
         unique case (pwr)
            PWR_SLEEP: sel = sleepSet;
            PWR_DEEP:  sel = deepSet;
            default:   sel = runSet;
         endcase
      end
      return sel & mask;
   endfunction : pcgSelect

   // fault decode of an access against the current enables
   logic unitOn;
   always_comb begin
      unitOn = accPort ? ((accBit < 5'(PORT_W)) && sQ.portEn[accBit]) : sQ.periphEn[accBit];
   end
   assign accFault = accValid && !unitOn;

   // outputs straight from state flops
   assign portClkEn   = sQ.portEn[PORT_W-1:0];
   assign periphClkEn = sQ.periphEn;
   assign regRdData   = sQ.rdData;
   // level interrupt while any enabled sticky bit stands
   assign irq         = |(sQ.irqStat & sQ.irqEn);

   // next state
   always_comb begin
      logic [IRQ_W-1:0] evt;
      sD  = sQ;
      evt = '0;
      // register writes; masks keep reserved bits at zero
      if (regWr) begin
         unique case (regAddr)
            OFF_RUN_PORT_GATE:     sD.runPort     = regWrData & PORT_MASK;
            OFF_SLEEP_PORT_GATE:   sD.sleepPort   = regWrData & PORT_MASK;
            OFF_DEEP_PORT_GATE:    sD.deepPort    = regWrData & PORT_MASK;
            OFF_RUN_PERIPH_GATE:   sD.runPeriph   = regWrData & PERIPH_MASK;
            OFF_SLEEP_PERIPH_GATE: sD.sleepPeriph = regWrData & PERIPH_MASK;
            OFF_DEEP_PERIPH_GATE:  sD.deepPeriph  = regWrData & PERIPH_MASK;
            OFF_RUN_CLOCK_CONFIG:  sD.autoGate    = regWrData[BIT_AUTO_GATE];
            OFF_IRQ_ENABLE:        sD.irqEn       = regWrData[IRQ_W-1:0];
            OFF_IRQ_CLEAR:         sD.irqStat     = sQ.irqStat & ~regWrData[IRQ_W-1:0];
            default: ;                                   // unmapped writes ignored
         endcase
      end
      // read data stands for one cycle only
      sD.rdData = '0;
      if (regRd) begin
         unique case (regAddr)
            OFF_RUN_PORT_GATE:     sD.rdData = sQ.runPort;
            OFF_SLEEP_PORT_GATE:   sD.rdData = sQ.sleepPort;
            OFF_DEEP_PORT_GATE:    sD.rdData = sQ.deepPort;
            OFF_RUN_PERIPH_GATE:   sD.rdData = sQ.runPeriph;
            OFF_SLEEP_PERIPH_GATE: sD.rdData = sQ.sleepPeriph;
            OFF_DEEP_PERIPH_GATE:  sD.rdData = sQ.deepPeriph;
            OFF_RUN_CLOCK_CONFIG:  sD.rdData[BIT_AUTO_GATE] = sQ.autoGate;
            OFF_IRQ_STATUS:        sD.rdData[IRQ_W-1:0] = sQ.irqStat;
            OFF_IRQ_ENABLE:        sD.rdData[IRQ_W-1:0] = sQ.irqEn;
            default:               sD.rdData = '0;       // clear reg and holes read zero
         endcase
      end
      // power state; deep sleep wins over sleep
      if (deepSleepReq) begin
         sD.pwr = PWR_DEEP;
      end else if (sleepReq) begin
         sD.pwr = PWR_SLEEP;
      end else begin
         sD.pwr = PWR_RUN;
      end
      // enables lag the registers by one cycle, glitch-free at the cells
      sD.portEn   = pcgSelect(sQ.pwr, sQ.autoGate, sQ.runPort, sQ.sleepPort,
                              sQ.deepPort, PORT_MASK);
      sD.periphEn = pcgSelect(sQ.pwr, sQ.autoGate, sQ.runPeriph, sQ.sleepPeriph,
                              sQ.deepPeriph, PERIPH_MASK);
      // sticky events; a set in the clear cycle wins
      evt[IRQ_FAULT]      = accFault;
      evt[IRQ_PWR_CHANGE] = (sD.pwr != sQ.pwr);
      sD.irqStat = sD.irqStat | evt;
   end

   // state register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sQ             <= '0;
         sQ.runPort     <= GATE_RESET;
         sQ.sleepPort   <= GATE_RESET;
         sQ.deepPort    <= GATE_RESET;
         sQ.runPeriph   <= GATE_RESET;
         sQ.sleepPeriph <= GATE_RESET;
         sQ.deepPeriph  <= GATE_RESET;
         sQ.portEn      <= GATE_RESET;
         sQ.periphEn    <= GATE_RESET;
         sQ.pwr         <= PWR_RUN;
         sQ.irqStat     <= IRQ_RESET;
         sQ.irqEn       <= IRQ_RESET;
      end else begin
         sQ <= sD;
      end
   end

   // checks on the enables and the bus answers
   property p_reset_off;
      @(posedge clk) $fell(sys_rst) |-> (portClkEn == '0) && (periphClkEn == '0);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("enable set after reset");

   // gating registers and state are all clear once reset lets go
   property p_reset_regs;
      @(posedge clk) $fell(sys_rst) |-> (sQ.runPort == '0) && (sQ.sleepPort == '0)
         && (sQ.deepPort == '0) && (sQ.runPeriph == '0) && (sQ.sleepPeriph == '0)
         && (sQ.deepPeriph == '0) && (sQ.pwr == PWR_RUN);
   endproperty
   a_reset_regs: assert property (p_reset_regs) else $error("gate register set after reset");

   // delayed copy of the write data, so checks can compare two edges later
   logic [31:0] regWrData_q1;
   logic [31:0] regWrData_q2;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regWrData_q1 <= 32'h0000_0000;
         regWrData_q2 <= 32'h0000_0000;
      end else begin
         regWrData_q1 <= regWrData;
         regWrData_q2 <= regWrData_q1;
      end
   end

   property p_run_on;
      @(posedge clk) disable iff (sys_rst)
      (regWr && regAddr == OFF_RUN_PORT_GATE && !sQ.autoGate) ##1 (!regWr && !sQ.autoGate)
      |-> ##1 (portClkEn == regWrData_q2[PORT_W-1:0]);
   endproperty
   a_run_on: assert property (p_run_on) else $error("run set not applied");

   property p_port_on;
      @(posedge clk) disable iff (sys_rst)
      (!sQ.autoGate && sQ.runPort[BIT_PORT_A]) |=> portClkEn[BIT_PORT_A];
   endproperty
   a_port_on: assert property (p_port_on) else $error("enabled port not clocked");

   // without automatic gating the run set drives the ports in every state
   property p_auto_off_port;
      @(posedge clk) disable iff (sys_rst)
      !sQ.autoGate |=> (portClkEn == $past(sQ.runPort[PORT_W-1:0]));
   endproperty
   a_auto_off_port: assert property (p_auto_off_port) else $error("run set not used");

   property p_run_state;
      @(posedge clk) disable iff (sys_rst)
      (sQ.pwr == PWR_RUN) |=> (periphClkEn == $past(sQ.runPeriph));
   endproperty
   a_run_state: assert property (p_run_state) else $error("run state set not used");

   property p_sleep_set;
      @(posedge clk) disable iff (sys_rst)
      (sQ.autoGate && sQ.pwr == PWR_SLEEP) |=> (portClkEn == $past(sQ.sleepPort[PORT_W-1:0]));
   endproperty
   a_sleep_set: assert property (p_sleep_set) else $error("sleep set not used");

   // deep sleep request beats a sleep request in the same cycle
   property p_deep_wins;
      @(posedge clk) disable iff (sys_rst)
      deepSleepReq |=> (sQ.pwr == PWR_DEEP);
   endproperty
   a_deep_wins: assert property (p_deep_wins) else $error("deep sleep not entered");

   property p_off_stays_off;
      @(posedge clk) disable iff (sys_rst)
      (!sQ.autoGate && !sQ.runPort[BIT_PORT_A]) |=> !portClkEn[BIT_PORT_A];
   endproperty
   a_off_stays_off: assert property (p_off_stays_off) else $error("gated port clocked");

   property p_fault;
      @(posedge clk) disable iff (sys_rst)
      (accValid && accPort && accBit < 5'(PORT_W) && !portClkEn[accBit[2:0]])
      |-> accFault ##1 sQ.irqStat[IRQ_FAULT];
   endproperty
   a_fault: assert property (p_fault) else $error("gated access not faulted");

   property p_no_fault;
      @(posedge clk) disable iff (sys_rst)
      (accValid && !accPort && periphClkEn[accBit]) |-> !accFault;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault on clocked unit");

   property p_fault_periph;
      @(posedge clk) disable iff (sys_rst)
      (accValid && !accPort && !periphClkEn[accBit]) |-> accFault;
   endproperty
   a_fault_periph: assert property (p_fault_periph) else $error("gated unit not faulted");

   // port indices past port E never name a clocked unit
   property p_port_high;
      @(posedge clk) disable iff (sys_rst)
      (accValid && accPort && accBit >= 5'(PORT_W)) |-> accFault;
   endproperty
   a_port_high: assert property (p_port_high) else $error("missing port not faulted");

   property p_reserved_zero;
      @(posedge clk) disable iff (sys_rst)
      (regRd && (regAddr == OFF_RUN_PORT_GATE || regAddr == OFF_SLEEP_PORT_GATE))
      |=> (regRdData[31:PORT_W] == '0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_deep_port_zero;
      @(posedge clk) disable iff (sys_rst)
      (regRd && regAddr == OFF_DEEP_PORT_GATE) |=> (regRdData[31:PORT_W] == '0);
   endproperty
   a_deep_port_zero: assert property (p_deep_port_zero) else $error("deep reserved set");

   property p_periph_zero;
      @(posedge clk) disable iff (sys_rst)
      (regRd && (regAddr == OFF_RUN_PERIPH_GATE || regAddr == OFF_SLEEP_PERIPH_GATE))
      |=> ((regRdData & ~PERIPH_MASK) == '0);
   endproperty
   a_periph_zero: assert property (p_periph_zero) else $error("periph reserved set");

   // masking happens on the way in, not only on read
   property p_mask_write;
      @(posedge clk) disable iff (sys_rst)
      (regWr && regAddr == OFF_RUN_PORT_GATE) |=> (sQ.runPort[31:PORT_W] == '0);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("reserved bits stored");

   // read data must not linger past its one cycle
   property p_rd_idle;
      @(posedge clk) disable iff (sys_rst)
      !regRd |=> (regRdData == '0);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

   property p_periph_map;
      @(posedge clk) disable iff (sys_rst) (periphClkEn & ~PERIPH_MASK) == '0;
   endproperty
   a_periph_map: assert property (p_periph_map) else $error("unmapped unit enabled");

   property p_sleep_ignored;
      @(posedge clk) disable iff (sys_rst)
      (!sQ.autoGate && sQ.pwr == PWR_SLEEP) |=> (periphClkEn == $past(sQ.runPeriph));
   endproperty
   a_sleep_ignored: assert property (p_sleep_ignored) else $error("sleep set used");

   property p_deep_set;
      @(posedge clk) disable iff (sys_rst)
      (sQ.autoGate && sQ.pwr == PWR_DEEP) |=> (portClkEn == $past(sQ.deepPort[PORT_W-1:0]));
   endproperty
   a_deep_set: assert property (p_deep_set) else $error("deep set not used");

   property p_deep_read;
      @(posedge clk) disable iff (sys_rst)
      (regWr && regAddr == OFF_DEEP_PERIPH_GATE) ##1 (regRd && regAddr == OFF_DEEP_PERIPH_GATE)
      |=> (regRdData == (regWrData_q2 & PERIPH_MASK));
   endproperty
   a_deep_read: assert property (p_deep_read) else $error("deep periph readback");

   property p_irq_level;
      @(posedge clk) disable iff (sys_rst)
      (sQ.irqStat[IRQ_FAULT] && sQ.irqEn[IRQ_FAULT]) |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

   property p_pwr_event;
      @(posedge clk) disable iff (sys_rst)
      (deepSleepReq && sQ.pwr != PWR_DEEP) |=> sQ.irqStat[IRQ_PWR_CHANGE];
   endproperty
   a_pwr_event: assert property (p_pwr_event) else $error("power change not noted");

   // a clear with no new fault in that cycle leaves the bit low
   property p_irq_clear;
      @(posedge clk) disable iff (sys_rst)
      (regWr && regAddr == OFF_IRQ_CLEAR && regWrData[IRQ_FAULT] && !accFault)
      |=> !sQ.irqStat[IRQ_FAULT];
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("fault bit not cleared");

   // main scenarios
   c_fault:     cover property (@(posedge clk) disable iff (sys_rst) accFault);
   c_sleep_use: cover property (@(posedge clk) disable iff (sys_rst)
                                sQ.autoGate && sQ.pwr == PWR_SLEEP && |portClkEn);
   c_irq:       cover property (@(posedge clk) disable iff (sys_rst) irq);
   c_deep_use:  cover property (@(posedge clk) disable iff (sys_rst)
                                sQ.autoGate && sQ.pwr == PWR_DEEP && |periphClkEn);
   c_clear:     cover property (@(posedge clk) disable iff (sys_rst)
                                regWr && regAddr == OFF_IRQ_CLEAR && |sQ.irqStat);

endmodule : pcg_clock_gate

// File: tb_pcg_clock_gate.sv
// self-checking bench for the peripheral clock gating block
// assumes one 100 MHz clock and the register map of pcg_pkg
`timescale 1ns/1ps

module tb_pcg_clock_gate
   import pcg_pkg::*;
;
   // dut ports
   logic              clk, sys_rst, regWr, regRd, sleepReq, deepSleepReq;
   logic              accValid, accPort, accFault, irq;
   logic [11:0]       regAddr;
   logic [31:0]       regWrData, regRdData, periphClkEn;
   logic [4:0]        accBit;
   logic [PORT_W-1:0] portClkEn;
   // bench state
   int                n_fail = 0;
   int                n_compared = 0;
   int                seed = 71969;
   logic [31:0]       expQ[$];
   logic              rdPend = 1'b0;
   logic [31:0]       val;
   logic [11:0]       offs [6] = '{OFF_RUN_PORT_GATE, OFF_SLEEP_PORT_GATE, OFF_DEEP_PORT_GATE,
                                   OFF_RUN_PERIPH_GATE, OFF_SLEEP_PERIPH_GATE, OFF_DEEP_PERIPH_GATE};

   pcg_clock_gate u_dut (
      .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .sleepReq(sleepReq), .deepSleepReq(deepSleepReq),
      .portClkEn(portClkEn), .periphClkEn(periphClkEn), .accValid(accValid),
      .accPort(accPort), .accBit(accBit), .accFault(accFault), .irq(irq));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chkOut(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chkOut

   // read data only stands one cycle, so it is taken at the edge closing that cycle
   always @(posedge clk) begin
      rdPend <= regRd;
      if (rdPend) begin
         if (expQ.size() == 0) chkOut("read note", 32'h1, 32'h0);
         else chkOut("read data", expQ.pop_front(), regRdData);
      end else chkOut("idle read data", 32'h0, regRdData);
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // the expected word is noted when the strobe goes out
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      expQ.push_back(e);
      @(posedge clk);
      regRd <= 1'b0;
   endtask : rd

   // enables follow a write or request two edges later; one spare edge
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   // one-cycle unit access, fault looked at mid-cycle
   task automatic acc(input logic p, input logic [4:0] b, input logic e);
      @(posedge clk);
      accValid <= 1'b1;
      accPort  <= p;
      accBit   <= b;
      @(negedge clk);
      chkOut("access fault", 32'(e), 32'(accFault));
      @(posedge clk);
      accValid <= 1'b0;
   endtask : acc

   task automatic finish_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end

   initial begin
      sys_rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 12'h000; regWrData = 32'h0;
      sleepReq = 1'b0; deepSleepReq = 1'b0; accValid = 1'b0; accPort = 1'b0; accBit = 5'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (offs[i]) rd(offs[i], GATE_RESET);
      rd(12'h200, 32'h0);
      chkOut("port enables", 32'h0, 32'(portClkEn));
      chkOut("periph enables", 32'h0, periphClkEn);
      // random port sets, indices 0 to 7 checked for a fault
      repeat (4) begin
         val = $random(seed);
         wr(OFF_RUN_PORT_GATE, val);
         rd(OFF_RUN_PORT_GATE, val & PORT_MASK);
         settle();
         chkOut("port enables", val & PORT_MASK, 32'(portClkEn));
         for (int b = 0; b < 8; b++) acc(1'b1, 5'(b), !(b < PORT_W && val[b]));
      end
      wr(OFF_RUN_PERIPH_GATE, 32'hFFFF_FFFF);
      rd(OFF_RUN_PERIPH_GATE, PERIPH_MASK);
      settle();
      chkOut("periph enables", PERIPH_MASK, periphClkEn);
      val = $random(seed);
      wr(OFF_RUN_PERIPH_GATE, val);
      settle();
      chkOut("periph enables", val & PERIPH_MASK, periphClkEn);
      for (int b = 0; b < 32; b++) acc(1'b0, 5'(b), !(PERIPH_MASK[b] && val[b]));
      // power state sets, first with automatic gating off
      wr(OFF_RUN_PORT_GATE, 32'h0000_0003);
      wr(OFF_SLEEP_PORT_GATE, 32'hFFFF_FFF4);
      rd(OFF_SLEEP_PORT_GATE, 32'h0000_0014);
      wr(OFF_DEEP_PORT_GATE, 32'h0000_0008);
      wr(OFF_DEEP_PERIPH_GATE, 32'h0100_0010);
      rd(OFF_DEEP_PERIPH_GATE, 32'h0100_0010);
      @(posedge clk);
      sleepReq <= 1'b1;
      settle();
      chkOut("port enables", 32'h3, 32'(portClkEn));
      wr(OFF_RUN_CLOCK_CONFIG, 32'h1 << BIT_AUTO_GATE);
      settle();
      chkOut("port enables", 32'h14, 32'(portClkEn));
      @(posedge clk);
      deepSleepReq <= 1'b1;
      settle();
      chkOut("port enables", 32'h8, 32'(portClkEn));
      chkOut("periph enables", 32'h0100_0010, periphClkEn);
      @(posedge clk);
      sleepReq     <= 1'b0;
      deepSleepReq <= 1'b0;
      settle();
      chkOut("port enables", 32'h3, 32'(portClkEn));
      chkOut("periph enables", val & PERIPH_MASK, periphClkEn);
      // interrupt raise, mask and clear
      wr(OFF_IRQ_CLEAR, 32'h3);
      rd(OFF_IRQ_STATUS, 32'h0);
      wr(OFF_IRQ_ENABLE, 32'h1);
      rd(OFF_IRQ_ENABLE, 32'h1);
      acc(1'b1, 5'd4, 1'b1);
      settle();
      chkOut("irq", 32'h1, 32'(irq));
      rd(OFF_IRQ_STATUS, 32'h1);
      wr(OFF_IRQ_ENABLE, 32'h0);
      settle();
      chkOut("irq", 32'h0, 32'(irq));
      wr(OFF_IRQ_ENABLE, 32'h3);
      settle();
      chkOut("irq", 32'h1, 32'(irq));
      wr(OFF_IRQ_CLEAR, 32'h3);
      rd(OFF_IRQ_CLEAR, 32'h0);
      settle();
      chkOut("irq", 32'h0, 32'(irq));
      // second reset in mid-run
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFF_RUN_PORT_GATE, GATE_RESET);
      settle();
      chkOut("port enables", 32'h0, 32'(portClkEn));
      finish_test();
   end
endmodule : tb_pcg_clock_gate
